// ---- rst_ctrl_params.svh ----
// Purpose: offsets, field positions, reset values and timing counts of the reset controller
// Assumes: 20 MHz mclk, byte-wide register port
// Notes: definitions only
`ifndef RST_CTRL_PARAMS_SVH
`define RST_CTRL_PARAMS_SVH
`define MAIN_CAUSE_ADDR 4'h0
`define LV_CAUSE_ADDR 4'h1
`define DET_CTRL_ADDR 4'h2
`define STAB_SEL_ADDR 4'h3
`define CAUSE_WDT_BIT 4
`define CAUSE_LV_BIT 0
`define DET_EN_BIT 7
`define DET_MODE_BIT 1
`define DET_FLAG_BIT 0
`define DET_LEVEL_BIT 0
`define DET_CTRL_LV_RESET 8'h82
`define STAB_SEL_RESET 3'h4
`define STAB_EXP_MIN 16
`define STAB_EXP_FLOOR 13
`define WDT_HOLD_NS 400
`define CLK_PERIOD_NS 50
`define WDT_HOLD_CYC ((`WDT_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLK_DIV_RESET 3'h7
`endif

// ---- rst_ctrl_pkg.sv ----
// Purpose: types of the reset controller
// Assumes: nothing
// Notes: constants live in rst_ctrl_params.svh
`default_nettype none
package rst_ctrl_pkg;
	typedef enum logic [1:0] {
		SRC_NONE,
		SRC_PIN_POC,
		SRC_WDT,
		SRC_LV
	} rst_src_t;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
	typedef enum {
		ST_RESET,
		ST_HOLD,
		ST_STAB,
		ST_RUN
	} seq_state_t;
endpackage
`default_nettype wire

// ---- reset_source_controller.sv ----
// Purpose: merges pin, power-on-clear, watchdog and undervoltage resets into one system reset
// Assumes: mclk is the oscillator clock fx; requests are asynchronous to mclk
// Notes: analog comparator is outside; it delivers a below-threshold level per level select
//
// Strobed register access and the address map are this design's own decisions.
`default_nettype none
`include "rst_ctrl_params.svh"
module reset_source_controller #(
	parameter int STAB_EXP_MAX = 19
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic reset_pin_n,
	input wire logic power_on_clear_reset,
	input wire logic watchdog_overflow_reset,
	input wire logic below_level_low,
	input wire logic below_level_high,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic sys_reset_n,
	output logic cpu_run,
	output logic periph_clk_en,
	output logic osc_run,
	output logic io_enable,
	output logic [2:0] sys_clk_div,
	output logic undervoltage_interrupt
);
	// the cap may sit below the default exponent; the counter is 24 bits wide
	if (STAB_EXP_MAX < `STAB_EXP_FLOOR || STAB_EXP_MAX > 23) begin : g_stab_range_check
		$error("STAB_EXP_MAX out of range");
	end

	rst_ctrl_pkg::reg_req_t req;
	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	// three-stage samplers for every outside request; a change counts when stage 2 and 3 agree
	logic [4:0] s1_q, s2_q, s3_q, flt_q;
	logic [4:0] flt_d;
	always_comb begin
		flt_d = flt_q;
		for (int i = 0; i < 5; i++) begin
			if (s2_q[i] == s3_q[i])
				flt_d[i] = s3_q[i];
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 5'h00;
			s2_q <= 5'h00;
			s3_q <= 5'h00;
			flt_q <= 5'h00;
		end else begin
			s1_q <= {below_level_high, below_level_low, watchdog_overflow_reset,
				power_on_clear_reset, ~reset_pin_n};
			s2_q <= s1_q;
			s3_q <= s2_q;
			flt_q <= flt_d;
		end
	end
	logic pin_low, poc_req, wdt_req, lv_low, lv_high;
	assign pin_low = flt_q[0];
	assign poc_req = flt_q[1];
	assign wdt_req = flt_q[2];
	assign lv_low = flt_q[3];
	assign lv_high = flt_q[4];

	// detector configuration; enable, mode and level select
	logic det_en_q, det_mode_q, det_level_q, det_en_d, det_mode_d, det_level_d;
	logic [2:0] stab_sel_q, stab_sel_d;
	logic below, det_flag, lv_reset_req, wdt_edge, wdt_prev_q;
	rst_ctrl_pkg::seq_state_t state_q, state_d;
	rst_ctrl_pkg::rst_src_t src_q, src_d;
	logic in_reset;
	assign below = det_level_q ? lv_high : lv_low;
	assign det_flag = det_en_q & below;
	assign lv_reset_req = det_flag & det_mode_q;
	assign wdt_edge = wdt_req & ~wdt_prev_q;
	// sticky interrupt line is left to the interrupt controller; this is the level request
	assign undervoltage_interrupt = det_flag & ~det_mode_q;

	// decide which source starts a reset; pin and power-on-clear take priority
	always_comb begin
		src_d = rst_ctrl_pkg::SRC_NONE;
		if (pin_low || poc_req)
			src_d = rst_ctrl_pkg::SRC_PIN_POC;
		else if (wdt_edge)
			src_d = rst_ctrl_pkg::SRC_WDT;
		else if (lv_reset_req && state_q == rst_ctrl_pkg::ST_RUN)
			src_d = rst_ctrl_pkg::SRC_LV;
	end

	// reset sequencer: hold, synchronised release, stabilization count
	logic [23:0] cnt_q, cnt_d;
	logic [23:0] stab_len;
	function automatic logic [23:0] stab_count(input logic [2:0] sel);
		int e;
		e = `STAB_EXP_MIN + int'(sel) - 4;
		if (e < `STAB_EXP_FLOOR)
			e = `STAB_EXP_FLOOR;
		if (e > STAB_EXP_MAX)
			e = STAB_EXP_MAX;
		return 24'(1 << e);
	endfunction
	assign stab_len = stab_count(stab_sel_q);
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			rst_ctrl_pkg::ST_RESET: begin
				cnt_d = 24'h000000;
				if (src_d == rst_ctrl_pkg::SRC_NONE && !lv_reset_req)
					state_d = rst_ctrl_pkg::ST_STAB;
			end
			rst_ctrl_pkg::ST_HOLD: begin
				cnt_d = cnt_q + 24'h000001;
				if (cnt_q >= 24'(`WDT_HOLD_CYC - 1)) begin
					state_d = rst_ctrl_pkg::ST_STAB;
					cnt_d = 24'h000000;
				end
			end
			rst_ctrl_pkg::ST_STAB: begin
				cnt_d = cnt_q + 24'h000001;
				if (cnt_q >= stab_len - 24'h000001)
					state_d = rst_ctrl_pkg::ST_RUN;
			end
			rst_ctrl_pkg::ST_RUN: cnt_d = 24'h000000;
			default: state_d = rst_ctrl_pkg::ST_RESET;
		endcase
		if (src_d == rst_ctrl_pkg::SRC_PIN_POC || src_d == rst_ctrl_pkg::SRC_LV) begin
			state_d = rst_ctrl_pkg::ST_RESET;
			cnt_d = 24'h000000;
		end else if (src_d == rst_ctrl_pkg::SRC_WDT) begin
			state_d = rst_ctrl_pkg::ST_HOLD;
			cnt_d = 24'h000000;
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= rst_ctrl_pkg::ST_RESET;
			cnt_q <= 24'h000000;
			src_q <= rst_ctrl_pkg::SRC_PIN_POC;
			wdt_prev_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			wdt_prev_q <= wdt_req;
			if (src_d != rst_ctrl_pkg::SRC_NONE)
				src_q <= src_d;
		end
	end
	assign in_reset = (state_q == rst_ctrl_pkg::ST_RESET) || (state_q == rst_ctrl_pkg::ST_HOLD);

	// outputs toward the rest of the chip, all registered
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sys_reset_n <= 1'b0;
			cpu_run <= 1'b0;
			periph_clk_en <= 1'b0;
			osc_run <= 1'b0;
			io_enable <= 1'b0;
			sys_clk_div <= `CLK_DIV_RESET;
		end else begin
			sys_reset_n <= ~in_reset;
			cpu_run <= (state_d == rst_ctrl_pkg::ST_RUN);
			periph_clk_en <= (state_d == rst_ctrl_pkg::ST_RUN);
			osc_run <= ~in_reset;
			io_enable <= (state_d == rst_ctrl_pkg::ST_RUN);
			sys_clk_div <= `CLK_DIV_RESET;
		end
	end

	// cause flags; pin/clear reset is also applied through rst_n itself
	logic main_wdt_q, main_lv_q, lv_cause_q, lv_bit4_q;
	logic main_wdt_d, main_lv_d, lv_cause_d, lv_bit4_d;
	always_comb begin
		main_wdt_d = main_wdt_q;
		main_lv_d = main_lv_q;
		lv_cause_d = lv_cause_q;
		lv_bit4_d = lv_bit4_q;
		if (req.wr && req.addr == `MAIN_CAUSE_ADDR) begin
			main_wdt_d = main_wdt_q & req.wdata[`CAUSE_WDT_BIT];
			main_lv_d = main_lv_q & req.wdata[`CAUSE_LV_BIT];
		end
		case (src_d)
			rst_ctrl_pkg::SRC_PIN_POC: begin
				main_wdt_d = 1'b0;
				main_lv_d = 1'b0;
				lv_cause_d = 1'b0;
				lv_bit4_d = 1'b0;
			end
			rst_ctrl_pkg::SRC_WDT: main_wdt_d = 1'b1;
			rst_ctrl_pkg::SRC_LV: begin
				lv_cause_d = 1'b1;
				main_lv_d = 1'b0;
			end
			default: ;
		endcase
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			main_wdt_q <= 1'b0;
			main_lv_q <= 1'b0;
			lv_cause_q <= 1'b0;
			lv_bit4_q <= 1'b0;
		end else begin
			main_wdt_q <= main_wdt_d;
			main_lv_q <= main_lv_d;
			lv_cause_q <= lv_cause_d;
			lv_bit4_q <= lv_bit4_d;
		end
	end

	// detector control and stabilization select; reset-cause dependent defaults
	always_comb begin
		det_en_d = det_en_q;
		det_mode_d = det_mode_q;
		det_level_d = det_level_q;
		stab_sel_d = stab_sel_q;
		if (req.wr && req.addr == `DET_CTRL_ADDR) begin
			det_en_d = req.wdata[`DET_EN_BIT];
			det_mode_d = req.wdata[`DET_MODE_BIT];
		end
		if (req.wr && req.addr == `STAB_SEL_ADDR) begin
			stab_sel_d = req.wdata[2:0];
			det_level_d = req.wdata[4 + `DET_LEVEL_BIT];
		end
		if (src_d == rst_ctrl_pkg::SRC_LV) begin
			det_en_d = 1'(`DET_CTRL_LV_RESET >> `DET_EN_BIT);
			det_mode_d = 1'b1;
			stab_sel_d = `STAB_SEL_RESET;
		end else if (src_d != rst_ctrl_pkg::SRC_NONE) begin
			det_en_d = 1'b0;
			det_mode_d = 1'b0;
			det_level_d = 1'b0;
			stab_sel_d = `STAB_SEL_RESET;
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			det_en_q <= 1'b0;
			det_mode_q <= 1'b0;
			det_level_q <= 1'b0;
			stab_sel_q <= `STAB_SEL_RESET;
		end else begin
			det_en_q <= det_en_d;
			det_mode_q <= det_mode_d;
			det_level_q <= det_level_d;
			stab_sel_q <= stab_sel_d;
		end
	end

	// read port: data one cycle after the strobe; unmapped reads give zero
	logic [7:0] rdata_d;
	always_comb begin
		rdata_d = 8'h00;
		case (req.addr)
			`MAIN_CAUSE_ADDR: begin
				rdata_d[`CAUSE_WDT_BIT] = main_wdt_q;
				rdata_d[`CAUSE_LV_BIT] = main_lv_q;
			end
			`LV_CAUSE_ADDR: begin
				rdata_d[4] = lv_bit4_q;
				rdata_d[0] = lv_cause_q;
			end
			`DET_CTRL_ADDR: begin
				rdata_d[`DET_EN_BIT] = det_en_q;
				rdata_d[`DET_MODE_BIT] = det_mode_q;
				rdata_d[`DET_FLAG_BIT] = det_flag;
			end
			`STAB_SEL_ADDR: rdata_d = {3'h0, det_level_q, 1'b0, stab_sel_q};
			default: rdata_d = 8'h00;
		endcase
		if (!req.rd)
			rdata_d = 8'h00;
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= rdata_d;
	end
endmodule
`default_nettype wire

// ---- rst_mon_monitor.sv ----
// Purpose: port-level checks of the reset controller
// Assumes: one clock domain, rst_n async active low
// Notes: bound into every reset_source_controller
`default_nettype none
`include "rst_ctrl_params.svh"
module rst_mon #(
	parameter int STAB_EXP_MAX = 19
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic reset_pin_n,
	input wire logic watchdog_overflow_reset,
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic sys_reset_n,
	input wire logic cpu_run,
	input wire logic periph_clk_en,
	input wire logic osc_run,
	input wire logic io_enable,
	input wire logic [2:0] sys_clk_div
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int STAB_MAX = (1 << STAB_EXP_MAX) + 16;
	logic [19:0] wait_d;
	logic [19:0] wait_q;
	// cycles out of reset with the cpu still held; cleared once it runs
	always_comb begin
		wait_d = (sys_reset_n && !cpu_run) ? wait_q + 20'h00001 : 20'h00000;
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q <= 20'h00000;
		end else begin
			wait_q <= wait_d;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_quiet_reset: assert property (!sys_reset_n |-> !io_enable && !cpu_run && !periph_clk_en)
		else $error("outputs active during reset");
	a_osc_stopped: assert property (!sys_reset_n |-> !osc_run)
		else $error("oscillator running during reset");
	a_div_eight: assert property (sys_clk_div == 3'h7)
		else $error("clock divider not eight");
	a_pin_holds: assert property (!reset_pin_n [*7] |-> !sys_reset_n)
		else $error("low pin did not hold reset");
	a_release_synced: assert property ($rose(sys_reset_n) |-> reset_pin_n && $past(reset_pin_n, 2))
		else $error("release not after a settled pin");
	a_stab_wait: assert property ($rose(cpu_run) |-> periph_clk_en && wait_q >= 8191 && wait_q <= STAB_MAX)
		else $error("stabilization wait wrong");
	a_wdt_enters: assert property ($rose(watchdog_overflow_reset) && cpu_run |-> ##[1:8] !sys_reset_n)
		else $error("overflow gave no reset");
	a_wdt_self_ends: assert property ($rose(watchdog_overflow_reset) && cpu_run |-> ##[9:24] $rose(sys_reset_n))
		else $error("overflow reset did not end itself");
	a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	a_lv_cause_zero: assert property ($past(reg_rd) && $past(reg_addr) == `LV_CAUSE_ADDR |-> (reg_rdata & 8'hee) == 8'h00)
		else $error("cause register spare bits set");
endmodule
bind reset_source_controller rst_mon #(.STAB_EXP_MAX(STAB_EXP_MAX)) u_mon (.mclk, .rst_n,
	.reset_pin_n, .watchdog_overflow_reset, .reg_addr, .reg_rd, .reg_rdata, .sys_reset_n,
	.cpu_run, .periph_clk_en, .osc_run, .io_enable, .sys_clk_div);
`default_nettype wire

// ---- reset_far_side.sv ----
// Purpose: far side: reset pin, clear circuit, watchdog and comparator
// Assumes: plain driven levels
// Notes: changes land just after a rising edge
`default_nettype none
module reset_far_side (
	input wire logic mclk,
	output logic reset_pin_n,
	output logic power_on_clear_reset,
	output logic watchdog_overflow_reset,
	output logic below_level_low,
	output logic below_level_high
);
	timeunit 1ns;
	timeprecision 1ns;
	// pin released, no requests, supply healthy at time zero
	initial begin
		reset_pin_n = 1'b1;
		power_on_clear_reset = 1'b0;
		watchdog_overflow_reset = 1'b0;
		below_level_low = 1'b0;
		below_level_high = 1'b0;
	end
	// all five lines move together at the next edge and stand until the next call
	task drive(input logic pin_n, input logic power_on_clear, input logic wdt, input logic lo, input logic hi);
		@(posedge mclk);
		reset_pin_n <= pin_n;
		power_on_clear_reset <= power_on_clear;
		watchdog_overflow_reset <= wdt;
		below_level_low <= lo;
		below_level_high <= hi;
	endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Purpose: self-checking bench of the reset controller
// Assumes: stabilization clamped to 2^13 cycles to keep the run short
// Notes: far side moved through src.drive
`default_nettype none
`include "rst_ctrl_params.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, sys_reset_n, cpu_run, periph_clk_en, osc_run, io_enable, undervoltage_interrupt;
	logic reset_pin_n, power_on_clear_reset, watchdog_overflow_reset, below_level_low;
	logic below_level_high;
	logic rst_n = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [2:0] sys_clk_div;
	int failures = 0;
	int n_compared = 0;
	reset_far_side src (.mclk, .reset_pin_n, .power_on_clear_reset, .watchdog_overflow_reset,
		.below_level_low, .below_level_high);
	reset_source_controller #(.STAB_EXP_MAX(13)) DUT (.mclk, .rst_n, .reset_pin_n,
		.power_on_clear_reset, .watchdog_overflow_reset, .below_level_low, .below_level_high,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sys_reset_n, .cpu_run,
		.periph_clk_en, .osc_run, .io_enable, .sys_clk_div, .undervoltage_interrupt);
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task test_done;
		if (failures == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// look only after the edge's own updates have landed
	task pause(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task rdchk(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata & mask, exp);
	endtask
	// bounded wait for the cpu; a hang ends the run
	task wait_run;
		for (int i = 0; i < 9000 && cpu_run !== 1'b1; i++) begin
			pause(1);
		end
		if (cpu_run !== 1'b1) begin
			failures++;
			$display("MISMATCH %0t cpu never started", $time);
			test_done;
		end
	endtask
	// two-cycle overflow request, since the samplers need two agreeing stages
	task wdt_reset;
		src.drive(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
		src.drive(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
		src.drive(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		pause(30);
		chk({7'h00, cpu_run}, 8'h00);
		wait_run;
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		#1;
		chk({4'h0, cpu_run, io_enable, periph_clk_en, osc_run}, 8'h00);
		chk({5'h00, sys_clk_div}, 8'h07);
		wait_run;
		chk({4'h0, cpu_run, io_enable, periph_clk_en, osc_run}, 8'h0f);
		rdchk(`LV_CAUSE_ADDR, 8'hef, 8'h00);
		rdchk(`MAIN_CAUSE_ADDR, 8'h11, 8'h00);
		wr(`LV_CAUSE_ADDR, 8'hff);
		rdchk(`LV_CAUSE_ADDR, 8'hef, 8'h00);
		rdchk(4'hf, 8'hff, 8'h00);
		wdt_reset;
		rdchk(`MAIN_CAUSE_ADDR, 8'h10, 8'h10);
		rdchk(`LV_CAUSE_ADDR, 8'hef, 8'h00);
		// interrupt mode on the low level, then the high level
		wr(`DET_CTRL_ADDR, 8'h80);
		src.drive(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		pause(4);
		chk({7'h00, undervoltage_interrupt}, 8'h01);
		wr(`STAB_SEL_ADDR, 8'h10);
		pause(4);
		chk({7'h00, undervoltage_interrupt}, 8'h00);
		src.drive(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
		pause(4);
		chk({7'h00, undervoltage_interrupt}, 8'h01);
		// reset mode while still below the high level
		wr(`DET_CTRL_ADDR, 8'h82);
		pause(20);
		chk({6'h00, undervoltage_interrupt, sys_reset_n}, 8'h00);
		src.drive(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		wait_run;
		rdchk(`LV_CAUSE_ADDR, 8'hef, 8'h01);
		rdchk(`MAIN_CAUSE_ADDR, 8'h10, 8'h10);
		wdt_reset;
		rdchk(`LV_CAUSE_ADDR, 8'hef, 8'h01);
		src.drive(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		pause(10);
		chk({4'h0, cpu_run, io_enable, periph_clk_en, osc_run}, 8'h00);
		src.drive(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		wait_run;
		rdchk(`MAIN_CAUSE_ADDR, 8'h11, 8'h00);
		rdchk(`LV_CAUSE_ADDR, 8'hef, 8'h00);
		wdt_reset;
		src.drive(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		pause(10);
		src.drive(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		wait_run;
		rdchk(`MAIN_CAUSE_ADDR, 8'h11, 8'h00);
		wdt_reset;
		wr(`MAIN_CAUSE_ADDR, 8'h00);
		rdchk(`MAIN_CAUSE_ADDR, 8'h11, 8'h00);
		// clearing write lands in the very cycle the overflow sets the flag
		src.drive(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
		src.drive(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
		src.drive(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		pause(1);
		wr(`MAIN_CAUSE_ADDR, 8'h00);
		wait_run;
		rdchk(`MAIN_CAUSE_ADDR, 8'h10, 8'h10);
		test_done;
	end
endmodule
`default_nettype wire
